//--- rtl/motor_startup_pkg.sv
// Purpose: constants, types and lookups for the start-up configuration block
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: printed offsets are register indices; byte address is four times the index
package motor_startup_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [31:0] IDX_FIRST = 32'h0000_0085;
  localparam logic [31:0] IDX_SECOND = 32'h0000_0086;
  localparam logic [31:0] ADDR_FIRST = IDX_FIRST << 2;
  localparam logic [31:0] ADDR_SECOND = IDX_SECOND << 2;
  localparam logic [31:0] RESET_FIRST = 32'h0000_0000;
  localparam logic [31:0] RESET_SECOND = 32'h0000_0000;
  localparam logic [31:0] MASK_FIRST = 32'hffff_fff7;
  localparam logic [31:0] MASK_SECOND = 32'hffff_ffff;
  // ------------------------------------------------------------
  // field positions of the first word
  // ------------------------------------------------------------
  localparam int THR_LSB = 9;
  localparam int THR_W = 5;
  localparam int RLS_BIT = 8;
  localparam int ADV_LSB = 6;
  localparam int RPT_LSB = 4;
  localparam int RSV_BIT = 3;
  localparam int RAMP_BIT = 2;
  localparam int BRAKE_BIT = 1;
  localparam int REV_BIT = 0;
  // ------------------------------------------------------------
  // timing and angle units
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int RELEASE_NS = 1000;
  localparam int RELEASE_CYC = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RELEASE_LAST = 8'(RELEASE_CYC - 1);
  localparam logic [3:0] SECTORS = 4'hc;
  localparam logic [3:0] ADV_STEP = 4'h3;
  localparam logic [13:0] THR_UNDEF_MA = 14'h0000;

  typedef struct packed {
    logic [4:0] thr;
    logic release_tristate;
    logic [1:0] adv;
    logic [1:0] repeats;
    logic ramp_en;
    logic brake_en;
    logic rev_sel;
  } ipd_cfg_t;

  typedef enum {ST_IDLE, ST_PULSE, ST_RELEASE, ST_DONE} seq_state_t;

  function automatic ipd_cfg_t unpack_first(input logic [31:0] w);
    ipd_cfg_t c;
    c.thr = w[THR_LSB +: THR_W];
    c.release_tristate = w[RLS_BIT];
    c.adv = w[ADV_LSB +: 2];
    c.repeats = w[RPT_LSB +: 2];
    c.ramp_en = w[RAMP_BIT];
    c.brake_en = w[BRAKE_BIT];
    c.rev_sel = w[REV_BIT];
    return c;
  endfunction : unpack_first

  // threshold code to milliamps, undefined codes give zero
  function automatic logic [13:0] thr_ma(input logic [4:0] code);
    case (code)
      5'h00: thr_ma = 14'd250;
      5'h01: thr_ma = 14'd500;
      5'h02: thr_ma = 14'd750;
      5'h03: thr_ma = 14'd1000;
      5'h04: thr_ma = 14'd1250;
      5'h05: thr_ma = 14'd1500;
      5'h06: thr_ma = 14'd2000;
      5'h07: thr_ma = 14'd2500;
      5'h08: thr_ma = 14'd3000;
      5'h09: thr_ma = 14'd3667;
      5'h0a: thr_ma = 14'd4000;
      5'h0b: thr_ma = 14'd4667;
      5'h0c: thr_ma = 14'd5000;
      5'h0d: thr_ma = 14'd5333;
      5'h0e: thr_ma = 14'd6000;
      5'h0f: thr_ma = 14'd6667;
      5'h10: thr_ma = 14'd7333;
      5'h11: thr_ma = 14'd8000;
      default: thr_ma = THR_UNDEF_MA;
    endcase
  endfunction : thr_ma

  // sector plus advance, in 30 degree steps, wrapped at a full turn
  function automatic logic [3:0] add_mod12(input logic [3:0] sector, input logic [1:0] adv);
    logic [4:0] s;
    s = {1'b0, sector} + 5'({adv, 2'b00} - {2'b00, adv});
    if (s >= {1'b0, SECTORS}) begin
      s = s - {1'b0, SECTORS};
    end
    return s[3:0];
  endfunction : add_mod12
endpackage : motor_startup_pkg

//--- rtl/motor_startup_cfg.sv
// Purpose: start-up configuration registers and rotor position pulse sequencer
// Assumes: single AHB-Lite master, word transfers, sensed sector inputs synchronous
// Notes: zero wait states; unmapped addresses read zero and ignore writes
//
// Overview of operation
// [R1] bits 13..9 pick pulse current threshold, 0h is 0.25 A up to 11h 8.0 A
// [R2] software must not write threshold codes 12h to 1Fh
// [R3] bit 8 clear brakes phases after each pulse, set leaves them tristated
// [R4] bits 7..6 add 0, 90, 180 or 270 degrees to detected position
// [R5] bits 5..4 run the detection one to four times
// [R6] bit 2 enables torque current ramp-down at open to closed loop handoff
// [R7] active braking only while bit 1 is set
// [R8] bit 0 selects forward or reverse settings for reverse drive
// [R9] second start-up word sits at index 86h and resets to zero
// [R10] reserved bit 3 of first word reads zero, writes ignored
`timescale 1ns/100ps
module motor_startup_cfg (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic detect_start,
  input wire logic current_reached,
  input wire logic [3:0] sensed_sector,
  input wire logic handoff_transition,
  input wire logic brake_request,
  input wire logic reverse_drive,
  output logic [13:0] current_threshold_ma,
  output logic pulse_drive,
  output logic phases_brake,
  output logic phases_tristate,
  output logic detect_busy,
  output logic detect_done,
  output logic [3:0] rotor_sector,
  output logic torque_rampdown_active,
  output logic active_brake,
  output logic use_reverse_settings,
  output motor_startup_pkg::ipd_cfg_t cfg_out
);
  import motor_startup_pkg::*;

  // ------------------------------------------------------------
  // bus slave and registers
  // ------------------------------------------------------------
  logic [31:0] startup_config_first;
  logic [31:0] startup_config_second;
  logic [31:0] next_first;
  logic [31:0] next_second;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic next_wr_pend;
  logic [31:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic addr_phase;
  ipd_cfg_t cfg;

  assign addr_phase = hsel && htrans[1] && hready;
  assign cfg = unpack_first(startup_config_first);

  always_comb begin
    next_first = startup_config_first;
    next_second = startup_config_second;
    if (wr_pend && wr_addr == ADDR_FIRST) begin
      next_first = hwdata & MASK_FIRST; // R10
    end
    if (wr_pend && wr_addr == ADDR_SECOND) begin
      next_second = hwdata & MASK_SECOND;
    end
    next_wr_pend = addr_phase && hwrite;
    next_wr_addr = haddr;
    next_hrdata = 32'h0000_0000;
    // read path sees a write finishing in this same cycle
    if (addr_phase && !hwrite) begin
      if (haddr == ADDR_FIRST) begin
        next_hrdata = next_first;
      end else if (haddr == ADDR_SECOND) begin
        next_hrdata = next_second; // R9
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      startup_config_first <= RESET_FIRST;
      startup_config_second <= RESET_SECOND; // R9
      wr_pend <= 1'b0;
      wr_addr <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      startup_config_first <= next_first;
      startup_config_second <= next_second;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // position detection sequencer
  // ------------------------------------------------------------
  seq_state_t state;
  seq_state_t next_state;
  ipd_cfg_t run_cfg;
  ipd_cfg_t next_run_cfg;
  logic [1:0] runs_done;
  logic [1:0] next_runs_done;
  logic [7:0] rel_cnt;
  logic [7:0] next_rel_cnt;
  logic [3:0] captured;
  logic [3:0] next_captured;
  logic [3:0] next_rotor;

  always_comb begin
    next_state = state;
    next_run_cfg = run_cfg;
    next_runs_done = runs_done;
    next_rel_cnt = rel_cnt;
    next_captured = captured;
    next_rotor = rotor_sector;
    case (state)
      ST_IDLE: begin
        if (detect_start) begin
          next_run_cfg = cfg;
          next_runs_done = 2'b00;
          next_state = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (current_reached) begin
          next_captured = sensed_sector;
          next_rel_cnt = 8'h00;
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (rel_cnt == RELEASE_LAST) begin
          if (runs_done == run_cfg.repeats) begin // R5
            next_rotor = add_mod12(captured, run_cfg.adv); // R4
            next_state = ST_DONE;
          end else begin
            next_runs_done = runs_done + 2'b01;
            next_state = ST_PULSE;
          end
        end else begin
          next_rel_cnt = rel_cnt + 8'h01;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      run_cfg <= '0;
      runs_done <= 2'b00;
      rel_cnt <= 8'h00;
      captured <= 4'h0;
      rotor_sector <= 4'h0;
    end else begin
      state <= next_state;
      run_cfg <= next_run_cfg;
      runs_done <= next_runs_done;
      rel_cnt <= next_rel_cnt;
      captured <= next_captured;
      rotor_sector <= next_rotor;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  logic [13:0] next_thr_ma;
  logic next_pulse_drive;
  logic next_brake;
  logic next_tristate;
  logic next_busy;
  logic next_done;
  logic next_ramp;
  logic next_active_brake;
  logic next_use_rev;

  always_comb begin
    next_thr_ma = thr_ma(cfg.thr); // R1
    next_pulse_drive = next_state == ST_PULSE;
    next_brake = next_state == ST_RELEASE && !next_run_cfg.release_tristate; // R3
    next_tristate = next_state == ST_RELEASE && next_run_cfg.release_tristate; // R3
    next_busy = next_state != ST_IDLE;
    next_done = next_state == ST_DONE;
    next_ramp = handoff_transition && cfg.ramp_en; // R6
    next_active_brake = brake_request && cfg.brake_en; // R7
    next_use_rev = reverse_drive && cfg.rev_sel; // R8
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      current_threshold_ma <= 14'h0000;
      pulse_drive <= 1'b0;
      phases_brake <= 1'b0;
      phases_tristate <= 1'b0;
      detect_busy <= 1'b0;
      detect_done <= 1'b0;
      torque_rampdown_active <= 1'b0;
      active_brake <= 1'b0;
      use_reverse_settings <= 1'b0;
      cfg_out <= '0;
    end else begin
      current_threshold_ma <= next_thr_ma;
      pulse_drive <= next_pulse_drive;
      phases_brake <= next_brake;
      phases_tristate <= next_tristate;
      detect_busy <= next_busy;
      detect_done <= next_done;
      torque_rampdown_active <= next_ramp;
      active_brake <= next_active_brake;
      use_reverse_settings <= next_use_rev;
      cfg_out <= cfg;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [2:0] pulse_count;
  logic second_written;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_count <= 3'h0;
      second_written <= 1'b0;
    end else begin
      if (state == ST_IDLE && detect_start) begin
        pulse_count <= 3'h0;
      end else if (state == ST_PULSE && current_reached) begin
        pulse_count <= pulse_count + 3'h1;
      end
      if (wr_pend && wr_addr == ADDR_SECOND) begin
        second_written <= 1'b1;
      end
    end
  end

  sequence s_wr_first;
    addr_phase && hwrite && haddr == ADDR_FIRST ##1 1'b1;
  endsequence

  sequence s_rd_first;
    addr_phase && !hwrite && haddr == ADDR_FIRST;
  endsequence

  a_thr_code_map: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    hresetn |=> current_threshold_ma == thr_ma($past(startup_config_first[THR_LSB +: THR_W])))
    else $error("threshold output does not match code");

  a_release_phase_mode: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    state == ST_RELEASE |-> phases_brake == !run_cfg.release_tristate && phases_tristate == run_cfg.release_tristate
      && !pulse_drive)
    else $error("release phase mode wrong");

  a_advance_angle_add: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    $rose(detect_done) |-> 32'(rotor_sector) == (32'(captured) + 32'(run_cfg.adv) * 3) % 12)
    else $error("advance angle not applied");

  a_repeat_run_count: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    $rose(detect_done) |-> pulse_count == {1'b0, run_cfg.repeats} + 3'h1)
    else $error("wrong number of detection runs");

  a_rampdown_gate: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    hresetn |=> torque_rampdown_active == ($past(handoff_transition) && $past(startup_config_first[RAMP_BIT])))
    else $error("ramp-down enable ignored");

  a_active_brake_gate: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    !startup_config_first[BRAKE_BIT] |=> !active_brake)
    else $error("active brake while disabled");

  a_reverse_select: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    reverse_drive && startup_config_first[REV_BIT] |=> use_reverse_settings)
    else $error("reverse settings not selected");

  a_second_reset_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    !second_written |-> startup_config_second == RESET_SECOND)
    else $error("second word not zero after reset");

  a_reserved_bit_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    s_wr_first |=> !startup_config_first[RSV_BIT] && startup_config_first[2:0] == $past(hwdata[2:0]))
    else $error("reserved bit stored or write lost");

  a_read_first_data: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    s_rd_first |=> hreadyout && !hrdata[RSV_BIT])
    else $error("reserved bit read nonzero");
endmodule : motor_startup_cfg

//--- testbench/motor_phase_model.sv
// Purpose: behavioural motor seen through the half-bridges during position pulses
// Assumes: current builds only while a pulse drives the phases
// Notes: delay sets how many driven cycles pass before the threshold is reached
`timescale 1ns/100ps
module motor_phase_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pulse_drive,
  input wire logic [2:0] delay,
  output logic current_reached,
  output logic [3:0] sensed_sector
);
  logic [2:0] age;
  logic [3:0] pos;
  // ------------------------------------------------------------
  // winding current and rotor sector
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      age <= 3'h0;
      pos <= 4'h0;
      current_reached <= 1'b0;
      sensed_sector <= 4'hf;
    end else begin
      pos <= (pos == 4'hb) ? 4'h0 : pos + 4'h1;
      age <= pulse_drive ? ((age == 3'h7) ? age : age + 3'h1) : 3'h0;
      current_reached <= pulse_drive && (age >= delay);
      // no valid sector outside a reached pulse
      sensed_sector <= (pulse_drive && (age >= delay)) ? pos : ~sensed_sector;
    end
  end
endmodule : motor_phase_model

//--- testbench/motor_startup_position_detect_config_bench.sv
// Purpose: self-checking bench for the start-up configuration block
// Assumes: one AHB-Lite master, hready fed back from hreadyout
// Notes: random values from a 16-bit shift register seeded with 31833
`timescale 1ns/100ps
module motor_startup_position_detect_config_bench;
  import motor_startup_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, w, r, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, dly = 3'h0;
  logic detect_start = 1'b0, handoff_transition = 1'b0, brake_request = 1'b0, reverse_drive = 1'b0;
  logic hreadyout, hresp, current_reached, pulse_drive, phases_brake, phases_tristate;
  logic detect_busy, detect_done, torque_rampdown_active, active_brake, use_reverse_settings;
  logic [3:0] sensed_sector, rotor_sector, sec, rs;
  logic [13:0] current_threshold_ma;
  ipd_cfg_t cfg_out;
  logic [15:0] seed = 16'h7c59;
  logic [13:0] ma_tab [18] = '{14'd250, 14'd500, 14'd750, 14'd1000, 14'd1250, 14'd1500, 14'd2000, 14'd2500,
    14'd3000, 14'd3667, 14'd4000, 14'd4667, 14'd5000, 14'd5333, 14'd6000, 14'd6667, 14'd7333, 14'd8000};
  int n_errors = 0, samples_checked = 0, npul, rel;
  logic prev, done;
  always #4 hclk = ~hclk;

  motor_startup_cfg u_motor_startup_cfg (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .detect_start(detect_start), .current_reached(current_reached),
    .sensed_sector(sensed_sector), .handoff_transition(handoff_transition), .brake_request(brake_request),
    .reverse_drive(reverse_drive), .current_threshold_ma(current_threshold_ma), .pulse_drive(pulse_drive),
    .phases_brake(phases_brake), .phases_tristate(phases_tristate), .detect_busy(detect_busy),
    .detect_done(detect_done), .rotor_sector(rotor_sector), .torque_rampdown_active(torque_rampdown_active),
    .active_brake(active_brake), .use_reverse_settings(use_reverse_settings), .cfg_out(cfg_out));
  motor_phase_model u_motor_phase_model (.hclk(hclk), .hresetn(hresetn), .pulse_drive(pulse_drive),
    .delay(dly), .current_reached(current_reached), .sensed_sector(sensed_sector));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    logic [31:0] v;
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    v[15:0] = seed;
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    v[31:16] = seed;
    return v;
  endfunction : rnd

  function automatic logic [31:0] exp_ma(input logic [4:0] code);
    return (code < 5'h12) ? {18'h0, ma_tab[code]} : 32'h0;
  endfunction : exp_ma

  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one phase: sample while settled, leave at the edge that ends it
  task automatic bus_wait(output logic [31:0] d);
    int n;
    logic rdy;
    n = 0;
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      d = hrdata;
      check("hresp okay", {31'h0, hresp}, 32'h0);
      @(posedge hclk);
      n++;
    end while (rdy !== 1'b1 && n < 64);
    if (rdy !== 1'b1) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : bus_wait

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    bus_wait(d);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    bus_wait(d);
  endtask : ahb

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    ahb(1'b0, ADDR_FIRST, 32'h0, rd);
    check("first reset", rd, 32'h0);
    ahb(1'b0, ADDR_SECOND, 32'h0, rd);
    check("second reset", rd, 32'h0);
    // every threshold code, all gate combinations
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      w = {r[31:14], 5'(i), r[8:3], 3'(i)};
      ahb(1'b1, ADDR_FIRST, w, rd);
      @(posedge hclk);
      {handoff_transition, brake_request, reverse_drive} <= r[6:4];
      ahb(1'b0, ADDR_FIRST, 32'h0, rd);
      check("first readback", rd, w & 32'hffff_fff7);
      check("threshold ma", {18'h0, current_threshold_ma}, exp_ma(5'(i)));
      check("cfg fields", {19'h0, cfg_out}, {19'h0, w[13:4], w[2:0]});
      check("rampdown", {31'h0, torque_rampdown_active}, {31'h0, w[2] & r[6]});
      check("brake gate", {31'h0, active_brake}, {31'h0, w[1] & r[5]});
      check("reverse sel", {31'h0, use_reverse_settings}, {31'h0, w[0] & r[4]});
    end
    for (int i = 0; i < 4; i++) begin
      w = rnd();
      ahb(1'b1, ADDR_SECOND, w, rd);
      ahb(1'b0, ADDR_SECOND, 32'h0, rd);
      check("second readback", rd, w);
      ahb(1'b1, ADDR_SECOND + 32'h8, ~w, rd);
      ahb(1'b0, ADDR_SECOND + 32'h8, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      ahb(1'b0, ADDR_SECOND, 32'h0, rd);
      check("second kept", rd, w);
    end
    // detection: every repeat count, angle and release mode
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      w = {18'h0, 5'(r[15:0] % 18), k[2], 2'(3 - k[1:0]), k[1:0], 4'h0};
      ahb(1'b1, ADDR_FIRST, w, rd);
      @(posedge hclk);
      dly <= r[18:16];
      detect_start <= 1'b1;
      npul = 0;
      rel = 0;
      prev = 1'b0;
      done = 1'b0;
      sec = 4'h0;
      for (int i = 0; i < 3000 && !done; i++) begin
        @(posedge hclk);
        detect_start <= (i == 3);
        @(negedge hclk);
        if (pulse_drive && !prev) npul++;
        prev = pulse_drive;
        if (pulse_drive && current_reached) sec = sensed_sector;
        if (pulse_drive || phases_brake || phases_tristate || detect_done) begin
          check("busy level", {31'h0, detect_busy}, 32'h1);
        end
        if (phases_brake || phases_tristate) begin
          rel++;
          check("release mode", {30'h0, phases_brake, phases_tristate}, {30'h0, !w[8], w[8]});
        end
        if (detect_done) begin
          done = 1'b1;
          rs = rotor_sector;
        end
      end
      if (!done) begin
        n_errors++;
        tally_and_finish();
      end
      @(negedge hclk);
      check("busy falls", {31'h0, detect_busy}, 32'h0);
      check("pulse count", 32'(npul), 32'(w[5:4]) + 32'h1);
      check("release cycles", 32'(rel), (32'(w[5:4]) + 32'h1) * RELEASE_CYC);
      check("advance sector", {28'h0, rs}, (32'(sec) + 32'h3 * 32'(w[7:6])) % 32'hc);
    end
    // second reset after the last detection run
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    ahb(1'b0, ADDR_SECOND, 32'h0, rd);
    check("second re-reset", rd, 32'h0);
    tally_and_finish();
  end
endmodule : motor_startup_position_detect_config_bench
